// ---- core/tpc_chan_cond.sv ----
// Purpose: conditions one channel byte
// Assumes: settings already sampled for this slot
// Notes:   purely combinational
`timescale 1ns/1ps
`include "tpc_params.svh"
module tpc_chan_cond
  import tpc_pkg::*;
(
  input  wire logic [7:0]     data_i,
  input  wire tpc_chan_ctrl_t ctrl_i,
  input  wire tpc_sig_ctrl_t  sig_i,
  input  wire logic [7:0]     channel_data_trunk_code_i,
  input  wire logic [2:0]     gsubst_i,
  input  wire logic           gstrk_i,
  input  wire logic           gap_en_i,
  input  wire logic           prbs_on_i,
  input  wire logic           prbs_dir_i,
  input  wire logic           prbs7_i,
  input  wire logic [7:0]     gen_bits_i,
  input  wire logic [7:0]     lb_i,
  input  wire logic [2:0]     mw_phase_i,
  input  wire logic           sig_frame_i,
  input  wire logic [1:0]     sig_sel_i,
  input  wire logic [3:0]     sys_abcd_i,
  output logic      [7:0]     data_o,
  output logic      [7:0]     gap_o,
  output logic                gen_use_o
);
  logic [2:0] sub;
  logic [7:0] inv;
  logic [3:0] src;
  logic [1:0] bit_idx;

  always_comb begin
    sub = (gsubst_i != `TPC_SUB_NONE) ? gsubst_i : ctrl_i.chan_subst_sel;
    case (sub)
      `TPC_SUB_CHANNEL_DATA_TRUNK_CODE: data_o = channel_data_trunk_code_i;
      `TPC_SUB_ALAW: data_o = (mw_phase_i[1:0] == 2'h1 || mw_phase_i[1:0] == 2'h2) ?
                              {mw_phase_i[2], 7'h21} : {mw_phase_i[2], 7'h34};
      `TPC_SUB_ULAW: data_o = (mw_phase_i[1:0] == 2'h1 || mw_phase_i[1:0] == 2'h2) ?
                              {mw_phase_i[2], 7'h0b} : {mw_phase_i[2], 7'h1e};
      `TPC_SUB_LOOP: data_o = lb_i;
      default:       data_o = data_i;
    endcase
    // generator bits overwrite the channel, 7 msbs only in 7-bit mode
    gen_use_o = prbs_on_i & ~prbs_dir_i;
    if (gen_use_o) begin
      data_o = prbs7_i ? {gen_bits_i[7:1], data_o[0]} : gen_bits_i;
    end
    // bit 1 of the channel is data[7]
    inv = (ctrl_i.msb_invert_sel ? `TPC_INV_MSB : 8'h00)
        | (ctrl_i.odd_invert_sel ? `TPC_INV_ODD : 8'h00)
        | (ctrl_i.even_invert_sel ? `TPC_INV_EVEN : 8'h00);
    data_o = data_o ^ inv;
    // robbed-bit signaling goes into bit 8
    src = (gstrk_i | sig_i.sig_trunk_en) ? sig_i.abcd : sys_abcd_i;
    bit_idx = 2'h3 - sig_sel_i;
    if (sig_frame_i & (sig_i.signaling_insert_en | gstrk_i | sig_i.sig_trunk_en)) begin
      data_o[0] = src[bit_idx];
    end
    if (!gap_en_i) begin
      gap_o = 8'h00;
    end else if (ctrl_i.chan_gap_sel) begin
      gap_o = 8'hff;
    end else begin
      gap_o = ctrl_i.lsb_gap_sel ? 8'h01 : 8'h00;
    end
  end
endmodule

// ---- core/tpc_params.svh ----
// Purpose: constants of the transmit payload conditioner
// Assumes: byte-wide register port
// Notes:   offsets are register indices on the plain port
`ifndef TPC_PARAMS_SVH
`define TPC_PARAMS_SVH
// ----------------------------------------------------------
// register map
// ----------------------------------------------------------
`define TPC_NUM_CH       24
`define TPC_CTRL_BASE    8'h01
`define TPC_CHANNEL_DATA_TRUNK_CODE_BASE    8'h21
`define TPC_STRK_BASE    8'h41
`define TPC_GCFG_ADDR    8'h60
`define TPC_PRBS_ADDR    8'h61
`define TPC_TXCFG_ADDR   8'h62
`define TPC_STAT_ADDR    8'h63
`define TPC_RST_VAL      8'h00
// ----------------------------------------------------------
// field positions
// ----------------------------------------------------------
`define TPC_GSUB_LSB     0
`define TPC_GSTRK_BIT    6
`define TPC_PDIR_BIT     1
`define TPC_PMODE_LSB    2
`define TPC_PER_CHANNEL_CTRL_EN_BIT     0
`define TPC_MASTER_BIT   1
// ----------------------------------------------------------
// codes
// ----------------------------------------------------------
`define TPC_SUB_NONE     3'h0
`define TPC_SUB_CHANNEL_DATA_TRUNK_CODE     3'h1
`define TPC_SUB_ALAW     3'h2
`define TPC_SUB_ULAW     3'h3
`define TPC_SUB_LOOP     3'h4
`define TPC_PMODE_8BIT   2'h1
`define TPC_PMODE_7BIT   2'h2
`define TPC_INV_EVEN     8'h55
`define TPC_INV_ODD      8'h2a
`define TPC_INV_MSB      8'h80
`endif

// ---- core/tpc_pkg.sv ----
// Purpose: types of the transmit payload conditioner
// Assumes: nothing
// Notes:   the two control struct layouts match the register bytes
package tpc_pkg;
  typedef struct packed {
    logic [2:0] chan_subst_sel;
    logic       msb_invert_sel;
    logic       odd_invert_sel;
    logic       even_invert_sel;
    logic       lsb_gap_sel;
    logic       chan_gap_sel;
  } tpc_chan_ctrl_t;

  typedef struct packed {
    logic       rsvd;
    logic       prbs_test;
    logic       signaling_insert_en;
    logic       sig_trunk_en;
    logic [3:0] abcd;
  } tpc_sig_ctrl_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] chan;
    logic [7:0] data;
  } tpc_beat_t;
endpackage

// ---- core/tpc_top.sv ----
// Purpose: per-channel transmit payload conditioning, 24 slots
// Assumes: one channel byte per beat from backplane logic
// Notes:   results appear one cycle after the beat
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "tpc_params.svh"
module tpc_top
  import tpc_pkg::*;
#(
  parameter int NUM_CH = `TPC_NUM_CH
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire tpc_beat_t  beat_i,
  input  wire logic       sig_frame_i,
  input  wire logic [1:0] sig_sel_i,
  input  wire logic [3:0] sys_abcd_i,
  input  wire logic [7:0] lb_data_i,
  input  wire logic [7:0] prbs_gen_bits_i,
  output tpc_beat_t       out_beat_o,
  output logic      [7:0] gap_mask_o,
  output logic            prbs_gen_adv_o,
  output logic      [3:0] prbs_gen_cnt_o,
  output logic            prbs_det_valid_o,
  output logic      [7:0] prbs_det_data_o,
  output logic      [3:0] prbs_det_cnt_o
);
  // ----------------------------------------------------------
  // register storage
  // ----------------------------------------------------------
  tpc_chan_ctrl_t ctrl_ff [NUM_CH];
  logic [7:0]     channel_data_trunk_code_ff [NUM_CH];
  tpc_sig_ctrl_t  strk_ff [NUM_CH];
  logic [7:0]     gcfg_ff;
  logic [7:0]     prbs_cfg_ff;
  logic [7:0]     txcfg_ff;
  logic [2:0]     mw_phase_ff;
  logic [4:0]     last_chan_ff;

  logic [7:0]     nxt_rdata;
  logic [4:0]     ridx;
  logic           in_ctrl;
  logic           in_channel_data_trunk_code;
  logic           in_strk;

  always_comb begin
    ridx = 5'h00;
    in_ctrl = 1'b0;
    in_channel_data_trunk_code = 1'b0;
    in_strk = 1'b0;
    if (reg_addr_i >= `TPC_CTRL_BASE &&
        reg_addr_i < `TPC_CTRL_BASE + 8'(NUM_CH)) begin
      in_ctrl = 1'b1;
      ridx = 5'(reg_addr_i - `TPC_CTRL_BASE);
    end else if (reg_addr_i >= `TPC_CHANNEL_DATA_TRUNK_CODE_BASE &&
                 reg_addr_i < `TPC_CHANNEL_DATA_TRUNK_CODE_BASE + 8'(NUM_CH)) begin
      in_channel_data_trunk_code = 1'b1;
      ridx = 5'(reg_addr_i - `TPC_CHANNEL_DATA_TRUNK_CODE_BASE);
    end else if (reg_addr_i >= `TPC_STRK_BASE &&
                 reg_addr_i < `TPC_STRK_BASE + 8'(NUM_CH)) begin
      in_strk = 1'b1;
      ridx = 5'(reg_addr_i - `TPC_STRK_BASE);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ctrl_ff[i] <= tpc_chan_ctrl_t'(`TPC_RST_VAL);
        channel_data_trunk_code_ff[i] <= `TPC_RST_VAL;
        strk_ff[i] <= tpc_sig_ctrl_t'(`TPC_RST_VAL);
      end
    end else if (reg_wr_i) begin
      if (in_ctrl) begin
        ctrl_ff[ridx] <= tpc_chan_ctrl_t'(reg_wdata_i);
      end
      if (in_channel_data_trunk_code) begin
        channel_data_trunk_code_ff[ridx] <= reg_wdata_i;
      end
      if (in_strk) begin
        strk_ff[ridx] <= tpc_sig_ctrl_t'({1'b0, reg_wdata_i[6:0]});
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      gcfg_ff <= `TPC_RST_VAL;
      prbs_cfg_ff <= `TPC_RST_VAL;
      txcfg_ff <= `TPC_RST_VAL;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `TPC_GCFG_ADDR) begin
        gcfg_ff <= reg_wdata_i & 8'h47;
      end
      if (reg_addr_i == `TPC_PRBS_ADDR) begin
        prbs_cfg_ff <= reg_wdata_i & 8'h0e;
      end
      if (reg_addr_i == `TPC_TXCFG_ADDR) begin
        txcfg_ff <= reg_wdata_i & 8'h03;
      end
    end
  end

  // ----------------------------------------------------------
  // read port
  // ----------------------------------------------------------
  always_comb begin
    nxt_rdata = 8'h00;
    if (in_ctrl) begin
      nxt_rdata = ctrl_ff[ridx];
    end else if (in_channel_data_trunk_code) begin
      nxt_rdata = channel_data_trunk_code_ff[ridx];
    end else if (in_strk) begin
      nxt_rdata = strk_ff[ridx];
    end else if (reg_addr_i == `TPC_GCFG_ADDR) begin
      nxt_rdata = gcfg_ff;
    end else if (reg_addr_i == `TPC_PRBS_ADDR) begin
      nxt_rdata = prbs_cfg_ff;
    end else if (reg_addr_i == `TPC_TXCFG_ADDR) begin
      nxt_rdata = txcfg_ff;
    end else if (reg_addr_i == `TPC_STAT_ADDR) begin
      nxt_rdata = {mw_phase_ff, last_chan_ff};
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? nxt_rdata : 8'h00;
    end
  end

  // ----------------------------------------------------------
  // slot sampling
  // ----------------------------------------------------------
  tpc_chan_ctrl_t cur_ctrl;
  tpc_sig_ctrl_t  cur_sig;
  logic [7:0]     cur_channel_data_trunk_code;
  logic           beat_ok;
  logic           prbs_mode_ok;
  logic           prbs_on;
  logic           prbs7;
  logic           gap_en;
  logic           sig_on;
  logic [2:0]     eff_sub;
  logic [7:0]     cond_data;
  logic [7:0]     cond_gap;
  logic           gen_use;

  // the beat's own cycle selects settings, so a mid-slot write counts next time
  always_comb begin
    beat_ok = beat_i.valid && (beat_i.chan < 5'(NUM_CH));
    cur_ctrl = tpc_chan_ctrl_t'(8'h00);
    cur_sig = tpc_sig_ctrl_t'(8'h00);
    cur_channel_data_trunk_code = 8'h00;
    if (beat_ok) begin
      cur_ctrl = ctrl_ff[beat_i.chan];
      cur_sig = strk_ff[beat_i.chan];
      cur_channel_data_trunk_code = channel_data_trunk_code_ff[beat_i.chan];
    end
    prbs_mode_ok = (prbs_cfg_ff[`TPC_PMODE_LSB +: 2] == `TPC_PMODE_8BIT) ||
                   (prbs_cfg_ff[`TPC_PMODE_LSB +: 2] == `TPC_PMODE_7BIT);
    prbs_on = prbs_mode_ok & cur_sig.prbs_test;
    prbs7 = prbs_cfg_ff[`TPC_PMODE_LSB +: 2] == `TPC_PMODE_7BIT;
    gap_en = txcfg_ff[`TPC_MASTER_BIT] & txcfg_ff[`TPC_PER_CHANNEL_CTRL_EN_BIT];
    sig_on = sig_frame_i & (cur_sig.signaling_insert_en | cur_sig.sig_trunk_en |
                            gcfg_ff[`TPC_GSTRK_BIT]);
    eff_sub = (gcfg_ff[2:0] != `TPC_SUB_NONE) ? gcfg_ff[2:0] : cur_ctrl.chan_subst_sel;
  end

  tpc_chan_cond u_cond (
    .data_i     (beat_i.data),
    .ctrl_i     (cur_ctrl),
    .sig_i      (cur_sig),
    .channel_data_trunk_code_i     (cur_channel_data_trunk_code),
    .gsubst_i   (gcfg_ff[`TPC_GSUB_LSB +: 3]),
    .gstrk_i    (gcfg_ff[`TPC_GSTRK_BIT]),
    .gap_en_i   (gap_en),
    .prbs_on_i  (prbs_on),
    .prbs_dir_i (prbs_cfg_ff[`TPC_PDIR_BIT]),
    .prbs7_i    (prbs7),
    .gen_bits_i (prbs_gen_bits_i),
    .lb_i       (lb_data_i),
    .mw_phase_i (mw_phase_ff),
    .sig_frame_i(sig_frame_i),
    .sig_sel_i  (sig_sel_i),
    .sys_abcd_i (sys_abcd_i),
    .data_o     (cond_data),
    .gap_o      (cond_gap),
    .gen_use_o  (gen_use)
  );

  // ----------------------------------------------------------
  // output stage
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      out_beat_o <= tpc_beat_t'(14'h0000);
      gap_mask_o <= 8'h00;
    end else begin
      out_beat_o.valid <= beat_i.valid;
      out_beat_o.chan <= beat_i.chan;
      out_beat_o.data <= beat_ok ? cond_data : beat_i.data;
      gap_mask_o <= (beat_i.valid && beat_ok) ? cond_gap : 8'h00;
    end
  end

  // generator advances only on selected slots, so the sequence stays continuous
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      prbs_gen_adv_o <= 1'b0;
      prbs_gen_cnt_o <= 4'h0;
      prbs_det_valid_o <= 1'b0;
      prbs_det_data_o <= 8'h00;
      prbs_det_cnt_o <= 4'h0;
    end else begin
      prbs_gen_adv_o <= beat_ok & gen_use;
      prbs_gen_cnt_o <= (beat_ok & gen_use) ? (prbs7 ? 4'h7 : 4'h8) : 4'h0;
      prbs_det_valid_o <= beat_ok & prbs_on & prbs_cfg_ff[`TPC_PDIR_BIT];
      prbs_det_data_o <= beat_i.data;
      prbs_det_cnt_o <= (beat_ok & prbs_on & prbs_cfg_ff[`TPC_PDIR_BIT]) ?
                        (prbs7 ? 4'h7 : 4'h8) : 4'h0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      mw_phase_ff <= 3'h0;
      last_chan_ff <= 5'h00;
    end else if (beat_ok) begin
      last_chan_ff <= beat_i.chan;
      if (beat_i.chan == 5'(NUM_CH - 1)) begin
        mw_phase_ff <= mw_phase_ff + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  logic plain;
  // reset is sampled too: a beat in the last reset cycle leaves a zero output behind
  assign plain = rst_b_i && beat_ok && eff_sub == `TPC_SUB_NONE && !prbs_on && !sig_on;

  AST_NO_INV: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    plain && cur_ctrl[4:2] == 3'b000 |=> out_beat_o.data == $past(beat_i.data))
    else $error("data changed with no inversion");
  AST_EVEN_INV: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    plain && cur_ctrl[4:2] == 3'b001 |=> out_beat_o.data == ($past(beat_i.data) ^ 8'h55))
    else $error("even inversion wrong");
  AST_ODD_INV: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    plain && cur_ctrl[4:2] == 3'b010 |=> out_beat_o.data == ($past(beat_i.data) ^ 8'h2a))
    else $error("odd inversion wrong");
  AST_MSB_INV: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    plain && cur_ctrl[4:2] == 3'b100 |=> out_beat_o.data == ($past(beat_i.data) ^ 8'h80))
    else $error("msb inversion wrong");
  AST_ALL_INV: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    plain && cur_ctrl[4:2] == 3'b111 |=> out_beat_o.data == ~$past(beat_i.data))
    else $error("full inversion wrong");
  AST_NO_GAP: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !gap_en |=> gap_mask_o == 8'h00)
    else $error("gap outside master mode");
  AST_LSB_GAP: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    beat_ok && gap_en && cur_ctrl.lsb_gap_sel && !cur_ctrl.chan_gap_sel
    |=> gap_mask_o == 8'h01)
    else $error("bit 8 gap wrong");
  AST_CH_GAP: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    beat_ok && gap_en && cur_ctrl.chan_gap_sel |=> gap_mask_o == 8'hff)
    else $error("channel gap wrong");
  AST_TRUNK: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    beat_ok && eff_sub == `TPC_SUB_CHANNEL_DATA_TRUNK_CODE && !prbs_on && !sig_on && cur_ctrl[4:2] == 3'b000
    |=> out_beat_o.data == $past(cur_channel_data_trunk_code))
    else $error("trunk code not substituted");
  AST_DET_DIR: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    prbs_det_valid_o |-> $past(prbs_cfg_ff[`TPC_PDIR_BIT]) && !prbs_gen_adv_o)
    else $error("detector fed in insert direction");
  AST_ODD_EVEN_INV: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    plain && cur_ctrl[4:2] == 3'b011 |=> out_beat_o.data == ($past(beat_i.data) ^ 8'h7f))
    else $error("bits 2 to 8 inversion wrong");
  AST_MSB_EVEN_INV: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    plain && cur_ctrl[4:2] == 3'b101 |=> out_beat_o.data == ($past(beat_i.data) ^ 8'hd5))
    else $error("msb and even inversion wrong");
  AST_MSB_ODD_INV: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    plain && cur_ctrl[4:2] == 3'b110 |=> out_beat_o.data == ($past(beat_i.data) ^ 8'haa))
    else $error("msb and odd inversion wrong");
  AST_PRBS_MODE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    beat_ok && !prbs_mode_ok |=> !prbs_gen_adv_o && !prbs_det_valid_o)
    else $error("channel test outside per-channel mode");
  AST_GEN_CNT: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    beat_ok && prbs_on && !prbs_cfg_ff[`TPC_PDIR_BIT]
    |=> prbs_gen_adv_o && prbs_gen_cnt_o == ($past(prbs7) ? 4'h7 : 4'h8))
    else $error("generator bit count wrong");
  AST_GEN_DATA: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    beat_ok && gen_use && !sig_on && cur_ctrl[4:2] == 3'b000
    |=> out_beat_o.data[7:1] == $past(prbs_gen_bits_i[7:1]))
    else $error("generator bits not inserted");
  AST_DET_FEED: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    beat_ok && prbs_on && prbs_cfg_ff[`TPC_PDIR_BIT]
    |=> prbs_det_valid_o && prbs_det_data_o == $past(beat_i.data))
    else $error("selected channel not passed to detector");
  AST_SIG_TRUNK: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    beat_ok && sig_frame_i && cur_sig.sig_trunk_en
    |=> out_beat_o.data[0] == $past(cur_sig.abcd[2'h3 - sig_sel_i]))
    else $error("channel signaling trunk code not applied");
  AST_GSIG_TRUNK: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    beat_ok && sig_frame_i && gcfg_ff[`TPC_GSTRK_BIT]
    |=> out_beat_o.data[0] == $past(cur_sig.abcd[2'h3 - sig_sel_i]))
    else $error("global signaling trunk code not applied");
  AST_SIG_SYS: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    beat_ok && sig_frame_i && cur_sig.signaling_insert_en && !cur_sig.sig_trunk_en &&
    !gcfg_ff[`TPC_GSTRK_BIT] |=> out_beat_o.data[0] == $past(sys_abcd_i[2'h3 - sig_sel_i]))
    else $error("system signaling not inserted");
  AST_SUBST_DEFER: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    beat_ok && gcfg_ff[2:0] == `TPC_SUB_NONE && cur_ctrl.chan_subst_sel == `TPC_SUB_LOOP &&
    !prbs_on && !sig_on && cur_ctrl[4:2] == 3'b000 |=> out_beat_o.data == $past(lb_data_i))
    else $error("per-channel substitution not used");
endmodule

// ---- dv/tb_tpc_top.sv ----
// Purpose: self-checking bench of the payload conditioner
// Assumes: reference model tracks every register write
// Notes:   status register 0x63 follows the modelled beat stream
`timescale 1ns/1ps
module tb_tpc_top
  import tpc_pkg::*;
();
  localparam logic [63:0] ALAW = 64'h3421_2134_b4a1_a1b4;
  localparam logic [63:0] ULAW = 64'h1e0b_0b1e_9e8b_8b9e;
  logic        sys_clk, rst_b, reg_wr, reg_rd, sig_frame, stream_en, armed;
  logic [7:0]  reg_addr, reg_wdata, rdata, lb, gen, gap, ddata;
  logic [1:0]  sig_sel;
  logic [3:0]  sys_abcd, gcnt, dcnt, sg;
  logic [31:0] rnd;
  tpc_beat_t   beat, ob;
  logic        gadv, dv;
  logic [7:0]  m_ctrl [24];
  logic [7:0]  m_channel_data_trunk_code [24];
  logic [7:0]  m_strk [24];
  logic [7:0]  m_gcfg, m_prbs, m_txcfg, ct, st;
  logic [7:0]  e_rd, e_chan, e_data, e_gap, e_ddata;
  logic [3:0]  e_gcnt, e_dcnt;
  logic [2:0]  sub;
  logic [4:0]  m_last;
  logic        e_valid, e_adv, e_dv;
  int          phase, n, cyc, num_errors, num_checks;

  tpc_top #(.NUM_CH(24)) DUT (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .beat_i(beat),
    .sig_frame_i(sig_frame), .sig_sel_i(sig_sel), .sys_abcd_i(sys_abcd), .lb_data_i(lb),
    .prbs_gen_bits_i(gen), .out_beat_o(ob), .gap_mask_o(gap), .prbs_gen_adv_o(gadv),
    .prbs_gen_cnt_o(gcnt), .prbs_det_valid_o(dv), .prbs_det_data_o(ddata),
    .prbs_det_cnt_o(dcnt));

  tpc_backplane_model u_bp (
    .clk_i(sys_clk), .en_i(stream_en), .rnd_i(rnd), .beat_o(beat), .sig_frame_o(sig_frame),
    .sig_sel_o(sig_sel), .abcd_o(sys_abcd), .lb_o(lb), .gen_o(gen));

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [7:0] rd_val(input logic [7:0] a);
    if (a >= 8'h01 && a <= 8'h18) return m_ctrl[a - 8'h01];
    if (a >= 8'h21 && a <= 8'h38) return m_channel_data_trunk_code[a - 8'h21];
    if (a >= 8'h41 && a <= 8'h58) return m_strk[a - 8'h41];
    if (a == 8'h60) return m_gcfg;
    if (a == 8'h61) return m_prbs;
    if (a == 8'h62) return m_txcfg;
    if (a == 8'h63) return {3'(phase), m_last};
    return 8'h00;
  endfunction

  // reserved bits are dropped so they read back as zero
  function automatic void wr_model(input logic [7:0] a, input logic [7:0] d);
    if (a >= 8'h01 && a <= 8'h18) m_ctrl[a - 8'h01] = d;
    else if (a >= 8'h21 && a <= 8'h38) m_channel_data_trunk_code[a - 8'h21] = d;
    else if (a >= 8'h41 && a <= 8'h58) m_strk[a - 8'h41] = d & 8'h7f;
    else if (a == 8'h60) m_gcfg = d & 8'h47;
    else if (a == 8'h61) m_prbs = d & 8'h0e;
    else if (a == 8'h62) m_txcfg = d & 8'h03;
  endfunction

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------
  // clock, random source, timeout
  // ----------------------------------------------------------
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) rnd <= xs(rnd);
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------
  // reference model: compare last result, then predict the next
  // ----------------------------------------------------------
  always @(posedge sys_clk) begin
    if (armed) begin
      chk("rdata", rdata, e_rd);
      chk("valid", {7'h00, ob.valid}, {7'h00, e_valid});
      if (e_valid) chk("chan", {3'h0, ob.chan}, e_chan);
      if (e_valid) chk("data", ob.data, e_data);
      chk("gap", gap, e_gap);
      chk("gen_adv", {3'h0, gadv, gcnt}, {3'h0, e_adv, e_gcnt});
      chk("det", {3'h0, dv, dcnt}, {3'h0, e_dv, e_dcnt});
      if (e_dv) chk("det_data", ddata, e_ddata);
    end
    e_rd = reg_rd ? rd_val(reg_addr) : 8'h00;
    {e_valid, e_adv, e_dv, e_gap, e_gcnt, e_dcnt} = '0;
    e_chan = {3'h0, beat.chan};
    e_data = beat.data;
    e_ddata = beat.data;
    if (!rst_b) begin
      foreach (m_ctrl[i]) {m_ctrl[i], m_channel_data_trunk_code[i], m_strk[i]} = '0;
      {m_gcfg, m_prbs, m_txcfg, e_rd, m_last} = '0;
      phase = 0;
      armed = 1'b1;
    end else begin
      e_valid = beat.valid;
      if (beat.valid && beat.chan < 5'd24) begin
        ct = m_ctrl[beat.chan];
        st = m_strk[beat.chan];
        m_last = beat.chan;
        sub = (m_gcfg[2:0] != 3'h0) ? m_gcfg[2:0] : ct[7:5];
        case (sub)
          3'h1: e_data = m_channel_data_trunk_code[beat.chan];
          3'h2: e_data = ALAW[63 - 8 * phase -: 8];
          3'h3: e_data = ULAW[63 - 8 * phase -: 8];
          3'h4: e_data = lb;
          default: ;
        endcase
        n = (m_prbs[3:2] == 2'h1) ? 8 : (m_prbs[3:2] == 2'h2) ? 7 : 0;
        if (n != 0 && st[6]) begin
          e_dv = m_prbs[1];
          e_adv = ~m_prbs[1];
          e_dcnt = m_prbs[1] ? 4'(n) : 4'h0;
          e_gcnt = m_prbs[1] ? 4'h0 : 4'(n);
          if (!m_prbs[1]) e_data = (n == 8) ? gen : {gen[7:1], e_data[0]};
        end
        e_data = e_data ^ (ct[4] ? 8'h80 : 8'h00) ^ (ct[3] ? 8'h2a : 8'h00)
                 ^ (ct[2] ? 8'h55 : 8'h00);
        if (m_txcfg[1:0] == 2'h3) e_gap = ct[0] ? 8'hff : {7'h00, ct[1]};
        sg = (st[4] | m_gcfg[6]) ? st[3:0] : sys_abcd;
        if (sig_frame && (st[5] | st[4] | m_gcfg[6])) e_data[0] = sg[2'h3 - sig_sel];
        if (beat.chan == 5'd23) phase = (phase + 1) % 8;
      end
      // a write in the beat's own cycle only counts from the next slot
      if (reg_wr) wr_model(reg_addr, reg_wdata);
    end
  end

  // ----------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------
  initial begin
    {sys_clk, rst_b, reg_wr, reg_rd, stream_en, armed} = '0;
    {reg_addr, reg_wdata, cyc, num_errors, num_checks, phase} = '0;
    rnd = 32'h4320_812f;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    // reset values, then random fill of every place, then read back
    for (int p = 0; p < 3; p++)
      for (int a = 0; a < 99; a++) bus(p == 1, p != 1, 8'(a), rnd[7:0]);
    stream_en <= 1'b1;
    for (int r = 0; r < 40; r++) begin
      for (int i = 0; i < 24; i++) begin
        bus(1'b1, 1'b0, 8'(8'h01 + i), {rnd[7:5], 3'(i + r), rnd[1:0]});
        bus(1'b1, 1'b0, 8'(8'h21 + i), rnd[15:8]);
        bus(1'b1, 1'b0, 8'(8'h41 + i), rnd[23:16]);
      end
      bus(1'b1, 1'b0, 8'h60, r[0] ? rnd[7:0] : (rnd[7:0] & 8'h40));
      bus(1'b1, 1'b0, 8'h61, {rnd[7:4], 2'(r), rnd[1:0]});
      bus(1'b1, 1'b0, 8'h62, rnd[7:0]);
      for (int k = 0; k < 30; k++)
        bus(1'b0, rnd[3], {1'b0, rnd[14:8]}, 8'h00);
    end
    // reset in mid-stream must clear every register
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 99; a++) bus(1'b0, 1'b1, 8'(a), 8'h00);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (3) @(posedge sys_clk);
    print_verdict();
  end
endmodule

// ---- dv/tpc_backplane_model.sv ----
// Purpose: backplane side feeding channel beats and side data
// Assumes: the bench hands over one random word per cycle
// Notes:   slot index runs to 25 so slots past the frame show up too
`timescale 1ns/1ps
module tpc_backplane_model
  import tpc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        en_i,
  input  wire logic [31:0] rnd_i,
  output tpc_beat_t        beat_o,
  output logic             sig_frame_o,
  output logic [1:0]       sig_sel_o,
  output logic [3:0]       abcd_o,
  output logic [7:0]       lb_o,
  output logic [7:0]       gen_o
);
  initial begin
    beat_o = '0;
    {sig_frame_o, sig_sel_o, abcd_o, lb_o, gen_o} = '0;
  end
  // an idle beat while en_i is high carries the inverse of the last byte; with en_i low the byte is held
  always @(posedge clk_i) begin
    beat_o.valid <= en_i & (rnd_i[2:0] != 3'h0);
    if (!en_i) begin
      beat_o.chan <= 5'h00;
    end else if (rnd_i[2:0] != 3'h0) begin
      beat_o.chan <= (beat_o.chan == 5'h19) ? 5'h00 : beat_o.chan + 5'h01;
      beat_o.data <= rnd_i[31:24];
    end else begin
      beat_o.data <= ~beat_o.data;
    end
    sig_frame_o <= rnd_i[3];
    sig_sel_o <= rnd_i[5:4];
    abcd_o <= rnd_i[9:6];
    lb_o <= rnd_i[17:10];
    gen_o <= rnd_i[25:18];
  end
endmodule
